// File: design/supervisor_defs.svh
/*
  Constants of the supervisor monitoring sequencer: register offsets, field
  positions, reset values and conversion timing.
  Assumes it is included by bare name; holds definitions only.
*/
// Summary of operation
// - temperature byte is signed, one degree per count
// - run bit samples temp, then rails, then supply
// - stop finishes the sequence; restart with temperature
// - fault: temp above hot, rail outside limits
// - fault sets status bit and pulls alert low
// - status read clears alert and status, comparator exempt
// - persisting fault reasserts alert after next conversion, except temperature in once mode
// - alert needs enable bit, blocked by mask bit
// - temperature 66ms, voltage 33ms conversions
// - line select bit slows oscillator to 51.2kHz
// - voltage codes unsigned, nominal reads 192
// - run bit cleared stops loop, registers stay usable
// - interrupt-clear bit releases alert except comparator-mode temperature, keeps status
// - loop start held off while interrupt-clear set
// - short-cycle bit cuts conversion rate by four
// - software reset bit restores defaults, self-clears
// - comparator temp alert follows fault, ignores reads
// - temperature mode from temperature config bits 1:0
// - mask bit blocks status bit and alert
// - default mode repeats until below hysteresis
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

`define REG_RES_RAIL_A 8'h20
`define REG_RES_RAIL_B 8'h21
`define REG_RES_RAIL_C 8'h22
`define REG_RES_SUPPLY 8'h23
`define REG_RES_TEMP 8'h27
`define REG_HI_RAIL_A 8'h2B
`define REG_LO_RAIL_A 8'h2C
`define REG_HI_RAIL_B 8'h2D
`define REG_LO_RAIL_B 8'h2E
`define REG_HI_RAIL_C 8'h2F
`define REG_LO_RAIL_C 8'h30
`define REG_HI_SUPPLY 8'h31
`define REG_LO_SUPPLY 8'h32
`define REG_HOT_LIMIT 8'h39
`define REG_HOT_HYST 8'h3A
`define REG_STATUS 8'h40
`define REG_MONITOR_CONFIG 8'h41
`define REG_MASK 8'h43
`define REG_TEMP_CONFIG 8'h4B

`define CFG_RUN 0
`define CFG_INT_EN 1
`define CFG_INT_CLR 3
`define CFG_LINE50 4
`define CFG_SHORT 5
`define CFG_SW_RESET 7
`define CFG_WRITE_MASK 8'h3B
`define STAT_TEMP 4

`define TMODE_ONCE 2'h1
`define TMODE_COMPARE 2'h2

`define RST_CONFIG 8'h00
`define RST_HI_LIMIT 8'hD3
`define RST_LO_LIMIT 8'hAD
`define RST_HOT_LIMIT 8'h50
`define RST_HOT_HYST 8'h41
`define RST_ZERO 8'h00

`define OSC_HZ 61400
`define TEMP_CONV_US 66000
`define VOLT_CONV_US 33000
`define TEMP_CONV_CYC 16'((64'd`TEMP_CONV_US * 64'd`OSC_HZ) / 64'd1000000)
`define VOLT_CONV_CYC 16'((64'd`VOLT_CONV_US * 64'd`OSC_HZ) / 64'd1000000)
`define SHORT_IDLE_DEF (3 * (int'(`TEMP_CONV_CYC) + 4 * int'(`VOLT_CONV_CYC)))
`define LAST_CHAN 3'h4

`endif

// File: design/supervisor_pkg.sv
/*
  Types shared by the supervisor sequencer files.
  Assumes nothing of its surroundings.
*/
package supervisor_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONVERT, SEQ_REST} seq_state_t;
  typedef logic [7:0] byte_t;
endpackage

// File: design/conv_if.sv
/*
  Link between the register side and the conversion sequencer.
  Assumes control levels come from clk-domain flops and results are held
  stable in the oscillator domain between done toggles.
*/
`timescale 1ns/100ps
interface conv_if;
  logic run_lvl;
  logic hold_lvl;
  logic short_lvl;
  logic done_tgl;
  logic [2:0] chan;
  supervisor_pkg::byte_t value;
  modport seq (input run_lvl, input hold_lvl, input short_lvl, output done_tgl, output chan, output value);
  modport mon (output run_lvl, output hold_lvl, output short_lvl, input done_tgl, input chan, input value);
endinterface

// File: design/conv_sequencer.sv
/*
  Conversion sequencer on the internal oscillator clock: steps the input
  multiplexer, times each conversion and hands each result over.
  Assumes conv_clk is the oscillator and adc_result is valid at the end of
  each conversion window for the channel on mux_sel.
*/
`timescale 1ns/100ps
`include "supervisor_defs.svh"
module conv_sequencer #(
  parameter int SHORT_IDLE_CYC = `SHORT_IDLE_DEF
) (
  input wire logic conv_clk,
  input wire logic rst,
  input wire logic [7:0] adc_result,
  output logic [2:0] mux_sel,
  conv_if.seq lnk
);
  supervisor_pkg::seq_state_t state_q;
  logic [1:0] rst_sync_q;
  logic crst;
  logic [2:0] ctl_s1_q;
  logic [2:0] ctl_s2_q;
  logic [7:0] adc_s1_q;
  logic [7:0] adc_s2_q;
  logic [15:0] cnt_q;
  logic [2:0] chan_q;
  logic done_tgl_q;
  logic [7:0] value_q;
  logic [2:0] res_chan_q;
  logic may_start;

  function automatic logic [15:0] conv_len(input logic [2:0] ch);
    conv_len = (ch == 3'h0) ? `TEMP_CONV_CYC : `VOLT_CONV_CYC;
  endfunction

  // reset asserts at once, releases in step with the oscillator
  always_ff @(posedge conv_clk or posedge rst) begin
    if (rst) begin
      rst_sync_q <= 2'h3;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b0};
    end
  end
  assign crst = rst_sync_q[1];

  always_ff @(posedge conv_clk or posedge crst) begin
    if (crst) begin
      ctl_s1_q <= 3'h0;
      ctl_s2_q <= 3'h0;
      adc_s1_q <= 8'h00;
      adc_s2_q <= 8'h00;
    end else begin
      ctl_s1_q <= {lnk.short_lvl, lnk.hold_lvl, lnk.run_lvl};
      ctl_s2_q <= ctl_s1_q;
      adc_s1_q <= adc_result;
      adc_s2_q <= adc_s1_q;
    end
  end

  assign may_start = ctl_s2_q[0] && !ctl_s2_q[1];

  always_ff @(posedge conv_clk or posedge crst) begin
    if (crst) begin
      state_q <= supervisor_pkg::SEQ_IDLE;
      cnt_q <= 16'h0000;
      chan_q <= 3'h0;
      done_tgl_q <= 1'b0;
      value_q <= 8'h00;
      res_chan_q <= 3'h0;
    end else begin
      case (state_q)
        supervisor_pkg::SEQ_IDLE: begin
          if (may_start) begin
            state_q <= supervisor_pkg::SEQ_CONVERT;
            chan_q <= 3'h0;
            cnt_q <= conv_len(3'h0);
          end
        end
        supervisor_pkg::SEQ_CONVERT: begin
          if (cnt_q > 16'h0001) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            value_q <= adc_s2_q;
            // label travels with its result; chan_q moves on at this same edge
            res_chan_q <= chan_q;
            done_tgl_q <= !done_tgl_q;
            if (chan_q != `LAST_CHAN) begin
              chan_q <= chan_q + 3'h1;
              cnt_q <= conv_len(chan_q + 3'h1);
            end else if (ctl_s2_q[2]) begin
              state_q <= supervisor_pkg::SEQ_REST;
              cnt_q <= 16'(SHORT_IDLE_CYC);
            end else if (may_start) begin
              chan_q <= 3'h0;
              cnt_q <= conv_len(3'h0);
            end else begin
              state_q <= supervisor_pkg::SEQ_IDLE;
            end
          end
        end
        supervisor_pkg::SEQ_REST: begin
          // idle time between sequences may be cut short by a stop
          if (!ctl_s2_q[0]) begin
            state_q <= supervisor_pkg::SEQ_IDLE;
          end else if (cnt_q > 16'h0001) begin
            cnt_q <= cnt_q - 16'h0001;
          end else if (may_start) begin
            state_q <= supervisor_pkg::SEQ_CONVERT;
            chan_q <= 3'h0;
            cnt_q <= conv_len(3'h0);
          end else begin
            state_q <= supervisor_pkg::SEQ_IDLE;
          end
        end
        default: begin
          state_q <= supervisor_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  assign mux_sel = chan_q;
  assign lnk.done_tgl = done_tgl_q;
  assign lnk.chan = res_chan_q;
  assign lnk.value = value_q;
endmodule // conv_sequencer

// File: design/supervisor_monitor_sequencer.sv
/*
  Register side of the voltage and temperature supervisor: limit, result,
  status, mask and configuration registers, fault comparison and alert pin.
  Assumes the serial engine drives reg_* on clk with one-cycle strobes, and
  that conv_clk is the internal conversion oscillator, unrelated to clk.
*/
`timescale 1ns/100ps
`include "supervisor_defs.svh"
module supervisor_monitor_sequencer #(
  parameter int SHORT_IDLE_CYC = `SHORT_IDLE_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_clk,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] adc_result,
  output logic [2:0] mux_sel,
  output logic osc_slow,
  output logic alert_o,
  output logic alert_oe
);
  conv_if link_if();

  logic [7:0] cfg_q;
  logic [4:0] status_q;
  logic [4:0] status_d;
  logic [4:0] mask_q;
  logic [1:0] tmode_q;
  logic [7:0] hot_q;
  logic [7:0] hyst_q;
  logic [7:0] hi_q [4];
  logic [7:0] lo_q [4];
  logic [7:0] result_q [5];
  logic [4:0] src_q;
  logic [4:0] src_d;
  logic temp_hot_q;
  logic temp_hot_d;
  logic [2:0] tgl_sync_q;
  logic done;
  logic is_temp;
  logic above;
  logic below;
  logic compare;
  logic [1:0] ridx;
  logic [4:0] evt;
  logic [4:0] clr;
  logic sw_reset;
  logic stat_rd;
  logic cfg_wr;
  logic [7:0] rd_val;
  logic [7:0] reg_rdata_q;
  logic alert_oe_q;
  logic alert_o_q;

  conv_sequencer #(.SHORT_IDLE_CYC(SHORT_IDLE_CYC)) u_seq (
    .conv_clk(conv_clk),
    .rst(rst),
    .adc_result(adc_result),
    .mux_sel(mux_sel),
    .lnk(link_if.seq)
  );

  assign link_if.run_lvl = cfg_q[`CFG_RUN];
  assign link_if.hold_lvl = cfg_q[`CFG_INT_CLR];
  assign link_if.short_lvl = cfg_q[`CFG_SHORT];

  assign cfg_wr = reg_wr && (reg_addr == `REG_MONITOR_CONFIG);
  assign sw_reset = cfg_wr && reg_wdata[`CFG_SW_RESET];
  assign stat_rd = reg_rd && (reg_addr == `REG_STATUS);
  assign compare = (tmode_q == `TMODE_COMPARE);

  // result word is held for thousands of clk cycles, so only the toggle
  // needs synchronising
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgl_sync_q <= 3'h0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], link_if.done_tgl};
    end
  end
  assign done = tgl_sync_q[2] ^ tgl_sync_q[1];
  assign is_temp = (link_if.chan == 3'h0);
  assign ridx = 2'(link_if.chan - 3'h1);

  always_comb begin
    above = $signed(link_if.value) > $signed(hot_q);
    below = $signed(link_if.value) < $signed(hyst_q);
    temp_hot_d = temp_hot_q;
    evt = 5'h00;
    if (done && is_temp) begin
      temp_hot_d = above ? 1'b1 : (below ? 1'b0 : temp_hot_q);
      case (tmode_q)
        `TMODE_ONCE: begin
          evt[`STAT_TEMP] = (above && !temp_hot_q) || (below && temp_hot_q);
        end
        `TMODE_COMPARE: begin
          evt[`STAT_TEMP] = temp_hot_d;
        end
        default: begin
          evt[`STAT_TEMP] = above || temp_hot_d;
        end
      endcase
    end else if (done) begin
      // unsigned compare of voltage codes
      evt[ridx] = (link_if.value > hi_q[ridx]) || (link_if.value < lo_q[ridx]);
    end
  end

  always_comb begin
    clr = 5'h00;
    if (stat_rd) begin
      clr = compare ? 5'h0F : 5'h1F;
    end
    // a new fault in the clearing cycle survives
    status_d = (status_q & ~clr) | (evt & ~mask_q);
    src_d = src_q & ~clr;
    if (cfg_wr && reg_wdata[`CFG_INT_CLR]) begin
      src_d = src_d & (compare ? 5'h10 : 5'h00);
    end
    src_d = src_d | (evt & ~mask_q);
    if (done && is_temp && compare) begin
      status_d[`STAT_TEMP] = temp_hot_d && !mask_q[`STAT_TEMP];
      src_d[`STAT_TEMP] = temp_hot_d && !mask_q[`STAT_TEMP];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= 5'h00;
      src_q <= 5'h00;
      temp_hot_q <= 1'b0;
    end else if (sw_reset) begin
      status_q <= 5'h00;
      src_q <= 5'h00;
      temp_hot_q <= 1'b0;
    end else begin
      status_q <= status_d;
      src_q <= src_d;
      temp_hot_q <= temp_hot_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 5; i++) begin
        result_q[i] <= `RST_ZERO;
      end
    end else if (sw_reset) begin
      for (int i = 0; i < 5; i++) begin
        result_q[i] <= `RST_ZERO;
      end
    end else if (done) begin
      result_q[link_if.chan] <= link_if.value;
    end
  end

  // software-written registers; the serial side stays live in shutdown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `RST_CONFIG;
      mask_q <= 5'h00;
      tmode_q <= 2'h0;
      hot_q <= `RST_HOT_LIMIT;
      hyst_q <= `RST_HOT_HYST;
      for (int i = 0; i < 4; i++) begin
        hi_q[i] <= `RST_HI_LIMIT;
        lo_q[i] <= `RST_LO_LIMIT;
      end
    end else if (sw_reset) begin
      cfg_q <= `RST_CONFIG;
      mask_q <= 5'h00;
      tmode_q <= 2'h0;
      hot_q <= `RST_HOT_LIMIT;
      hyst_q <= `RST_HOT_HYST;
      for (int i = 0; i < 4; i++) begin
        hi_q[i] <= `RST_HI_LIMIT;
        lo_q[i] <= `RST_LO_LIMIT;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_MONITOR_CONFIG: cfg_q <= reg_wdata & `CFG_WRITE_MASK;
        `REG_MASK: mask_q <= reg_wdata[4:0];
        `REG_TEMP_CONFIG: tmode_q <= reg_wdata[1:0];
        `REG_HOT_LIMIT: hot_q <= reg_wdata;
        `REG_HOT_HYST: hyst_q <= reg_wdata;
        `REG_HI_RAIL_A: hi_q[0] <= reg_wdata;
        `REG_LO_RAIL_A: lo_q[0] <= reg_wdata;
        `REG_HI_RAIL_B: hi_q[1] <= reg_wdata;
        `REG_LO_RAIL_B: lo_q[1] <= reg_wdata;
        `REG_HI_RAIL_C: hi_q[2] <= reg_wdata;
        `REG_LO_RAIL_C: lo_q[2] <= reg_wdata;
        `REG_HI_SUPPLY: hi_q[3] <= reg_wdata;
        `REG_LO_SUPPLY: lo_q[3] <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (reg_addr)
      `REG_RES_TEMP: rd_val = result_q[0];
      `REG_RES_RAIL_A: rd_val = result_q[1];
      `REG_RES_RAIL_B: rd_val = result_q[2];
      `REG_RES_RAIL_C: rd_val = result_q[3];
      `REG_RES_SUPPLY: rd_val = result_q[4];
      `REG_HI_RAIL_A: rd_val = hi_q[0];
      `REG_LO_RAIL_A: rd_val = lo_q[0];
      `REG_HI_RAIL_B: rd_val = hi_q[1];
      `REG_LO_RAIL_B: rd_val = lo_q[1];
      `REG_HI_RAIL_C: rd_val = hi_q[2];
      `REG_LO_RAIL_C: rd_val = lo_q[2];
      `REG_HI_SUPPLY: rd_val = hi_q[3];
      `REG_LO_SUPPLY: rd_val = lo_q[3];
      `REG_HOT_LIMIT: rd_val = hot_q;
      `REG_HOT_HYST: rd_val = hyst_q;
      `REG_MONITOR_CONFIG: rd_val = cfg_q;
      `REG_STATUS: rd_val = {3'h0, status_q};
      `REG_MASK: rd_val = {3'h0, mask_q};
      `REG_TEMP_CONFIG: rd_val = {6'h00, tmode_q};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_val;
    end
  end

  // open drain: only ever drives low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alert_oe_q <= 1'b0;
      alert_o_q <= 1'b0;
    end else begin
      alert_oe_q <= cfg_q[`CFG_INT_EN] && |(src_q & ~mask_q);
      alert_o_q <= 1'b0;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign osc_slow = cfg_q[`CFG_LINE50];
  assign alert_oe = alert_oe_q;
  assign alert_o = alert_o_q;
endmodule // supervisor_monitor_sequencer

// File: verification/supervisor_monitor_sequencer_checker.sv
/*
  Port assertions for the supervisor sequencer.
  Assumes it is bound onto the top module and sees only its ports.
*/
`timescale 1ns/100ps
`include "supervisor_defs.svh"
module supervisor_monitor_sequencer_checker #(
  parameter int SHORT_IDLE_CYC = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic conv_clk,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] adc_result,
  input wire logic [2:0] mux_sel,
  input wire logic osc_slow,
  input wire logic alert_o,
  input wire logic alert_oe
);
  logic en_q;
  logic [2:0] prev_q;
  logic [15:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h41) begin
      en_q <= reg_wdata[1] & ~reg_wdata[7];
    end
  end
  // counts samples of one channel; idle stretches the supply window, or the temperature one after reset
  always_ff @(posedge conv_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 3'h0;
      cnt_q <= 16'h0001;
    end else begin
      prev_q <= mux_sel;
      cnt_q <= (mux_sel == prev_q) ? cnt_q + 16'h0001 : 16'h0001;
    end
  end
  sequence cfg_wr_s;
    reg_wr && reg_addr == 8'h41;
  endsequence
  a_od_data_low: assert property (@(posedge clk) disable iff (rst) !alert_o)
    else $error("alert data line not low");
  a_alert_enable_gate: assert property (@(posedge clk) disable iff (rst)
    !en_q && !$past(en_q) && !$past(en_q, 2) |-> !alert_oe) else $error("alert while disabled");
  a_cfg_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == 8'h41 |=> (reg_rdata & 8'hC4) == 8'h00) else $error("config reserved bits set");
  a_status_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == 8'h40 |=> reg_rdata[7:5] == 3'h0) else $error("status reserved bits set");
  a_rdata_holds: assert property (@(posedge clk) disable iff (rst)
    !reg_rd && !(reg_wr && reg_addr == 8'h41 && reg_wdata[7]) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_slow_follows_cfg: assert property (@(posedge clk) disable iff (rst)
    cfg_wr_s ##0 !reg_wdata[7] |=> ##1 osc_slow == $past(reg_wdata[4], 2)) else $error("slow select wrong");
  a_swreset_clears: assert property (@(posedge clk) disable iff (rst)
    cfg_wr_s ##0 reg_wdata[7] |=> ##1 !osc_slow && !alert_oe) else $error("soft reset left state");
  a_mux_order: assert property (@(posedge conv_clk) disable iff (rst) mux_sel != prev_q |->
    mux_sel <= `LAST_CHAN && (mux_sel == prev_q + 3'h1 || mux_sel == 3'h0)) else $error("channel order broken");
  a_volt_window: assert property (@(posedge conv_clk) disable iff (rst)
    mux_sel != prev_q && prev_q inside {3'h1, 3'h2, 3'h3} |-> cnt_q == `VOLT_CONV_CYC)
    else $error("voltage window length wrong");
endmodule // supervisor_monitor_sequencer_checker

bind supervisor_monitor_sequencer supervisor_monitor_sequencer_checker #(.SHORT_IDLE_CYC(SHORT_IDLE_CYC)) i_chk (
  .clk(clk), .rst(rst), .conv_clk(conv_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_result(adc_result), .mux_sel(mux_sel), .osc_slow(osc_slow),
  .alert_o(alert_o), .alert_oe(alert_oe));

// File: verification/reg_host_model.sv
/*
  Host side of the register port: one-cycle write and read strobes.
  Assumes clk is the register clock; reg_rdata answers one edge later.
*/
`timescale 1ns/100ps
module reg_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // released lines must not keep showing the last value
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    // read data stands from the strobe edge until the next read
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule // reg_host_model

// File: verification/supervisor_monitor_sequencer_test.sv
/*
  Self-checking bench for the supervisor sequencer.
  Assumes the bound checker and the host model beside it.
*/
`timescale 1ns/100ps
module supervisor_monitor_sequencer_test;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic conv_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, osc_slow, alert_o, alert_oe;
  logic [7:0] adc_result = 8'h00;
  logic [2:0] mux_sel;
  logic [7:0] adc_tab [0:7];
  logic [7:0] ra [0:15] = '{8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h39, 8'h3A,
    8'h40, 8'h41, 8'h43, 8'h4B, 8'h42, 8'h27};
  logic [7:0] rv [0:15] = '{8'hD3, 8'hAD, 8'hD3, 8'hAD, 8'hD3, 8'hAD, 8'hD3, 8'hAD, 8'h50, 8'h41,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  initial begin
    #2;
    forever #16 conv_clk = ~conv_clk;
  end
  always @(posedge clk) adc_result <= adc_tab[mux_sel];
  supervisor_monitor_sequencer #(.SHORT_IDLE_CYC(50)) i_dut (.clk(clk), .rst(rst), .conv_clk(conv_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_result(adc_result), .mux_sel(mux_sel), .osc_slow(osc_slow), .alert_o(alert_o), .alert_oe(alert_oe));
  reg_host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic end_sim;
    $display("counts checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > LIMIT) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_host.rd(a, v);
    check(v, exp);
  endtask
  task automatic wait_chan(input logic [2:0] ch);
    int n;
    n = 0;
    while (mux_sel !== ch && n < 50000) begin
      @(posedge clk);
      n++;
    end
    if (mux_sel !== ch) n_mismatch++;
  endtask
  // temp above hot limit is signed, rails unsigned against both limits
  function automatic logic [7:0] exp_status(input logic [7:0] msk);
    logic [7:0] s;
    s = 8'h00;
    s[4] = $signed(adc_tab[0]) > $signed(rv[8]);
    for (int i = 1; i < 5; i++) s[i-1] = adc_tab[i] > 8'hD3 || adc_tab[i] < 8'hAD;
    return s & ~msk;
  endfunction
  initial begin
    void'($urandom(32'hD0810004));
    adc_tab = '{8'h7D, 8'h00, 8'hFF, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
    adc_tab[1] = 8'hAD + 8'($urandom_range(0, 38));
    adc_tab[4] = 8'hAD + 8'($urandom_range(0, 38));
    repeat (4) @(posedge clk);
    repeat (3) @(posedge conv_clk);
    @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) rchk(ra[i], rv[i]);
    $display("test reset_values done");
    i_host.wr(8'h43, 8'h04);
    for (int i = 0; i < 10; i++) i_host.wr(ra[i], rv[i]);
    i_host.wr(8'h41, 8'h03);
    wait_chan(3'h1);
    // stop during a rail window: the pass must still reach the supply
    i_host.wr(8'h41, 8'h02);
    wait_chan(3'h4);
    repeat (2100) @(posedge conv_clk);
    repeat (10) @(posedge clk);
    for (int i = 0; i < 5; i++) rchk((i == 0) ? 8'h27 : 8'(8'h1F + i), adc_tab[i]);
    check({7'h00, alert_oe}, 8'h01);
    check({7'h00, alert_o}, 8'h00);
    $display("test sequence done");
    i_host.wr(8'h41, 8'h0A);
    repeat (3) @(posedge clk);
    check({7'h00, alert_oe}, 8'h00);
    rchk(8'h40, exp_status(8'h04));
    rchk(8'h40, 8'h00);
    rchk(8'h41, 8'h0A);
    $display("test clear done");
    i_host.wr(8'h41, 8'h10);
    repeat (3) @(posedge clk);
    check({7'h00, osc_slow}, 8'h01);
    i_host.wr(8'h41, 8'h93);
    repeat (3) @(posedge clk);
    check({7'h00, osc_slow}, 8'h00);
    for (int i = 10; i < 16; i++) rchk(ra[i], rv[i]);
    rchk(8'h39, 8'h50);
    $display("test soft_reset done");
    // supply was the last input converted, so the mux still rests on it
    i_host.wr(8'h4B, 8'h02);
    i_host.wr(8'h41, 8'h0B);
    repeat (10) @(posedge conv_clk);
    @(posedge clk);
    check({5'h00, mux_sel}, 8'h04);
    i_host.wr(8'h41, 8'h03);
    repeat (10) @(posedge conv_clk);
    @(posedge clk);
    check({5'h00, mux_sel}, 8'h00);
    wait_chan(3'h1);
    repeat (10) @(posedge clk);
    rchk(8'h40, exp_status(8'h0F));
    rchk(8'h40, exp_status(8'h0F));
    check({7'h00, alert_oe}, 8'h01);
    $display("test comparator done");
    end_sim();
  end
endmodule // supervisor_monitor_sequencer_test
